// *** hw/pin_sync8.sv ***
// Two-stage synchroniser for a byte of pin levels
`timescale 1ns/1ps
module pin_sync8
   import port_pins_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Levels
   input wire byte_t async_in,
   output byte_t sync_out
);

   byte_t stage1;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage1 <= 8'h00;
         sync_out <= 8'h00;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// *** hw/port_abc_pin_control.sv ***
// Three 8-bit ports with direction, latches and third-port control mode
//
// Functional notes
// - First port pins individually input or output
// - Reset makes first port inputs, floating
// - Hardware stop floats all first port pins
// - Second port pins individually input or output
// - Reset makes second port inputs, floating
// - Hardware stop floats all second port pins
// - Select bit picks port or peripheral role
// - Third port control roles fixed per pin
// - Port-mode third pins use direction register
// - Pin 0 control drives serial transmit data
// - Pin 1 control feeds serial receive data
// - Serial clock direction follows clock source
// - Edge pin interrupts on fall, clocks timer
// - Timer pin outputs timer square wave
// - Counter pin delivers pulses to counter
// - Reset and stop float third port pins
// - Counter pins drive counter waveforms
`timescale 1ns/1ps
`include "port_pins_cfg.svh"
module port_abc_pin_control
   import port_pins_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Hardware stop, active low pin level
   input wire logic hw_stop_n_in,
   // Register port
   input wire reg_req_s reg_req_in,
   output byte_t reg_rdata_out,
   // First port pins
   input wire byte_t first_port_pins_in,
   output byte_t first_port_pins_out,
   output byte_t first_port_pins_oe_n_out,
   // Second port pins
   input wire byte_t second_port_pins_in,
   output byte_t second_port_pins_out,
   output byte_t second_port_pins_oe_n_out,
   // Third port pins
   input wire byte_t third_port_pins_in,
   output byte_t third_port_pins_out,
   output byte_t third_port_pins_oe_n_out,
   // Peripheral side
   input wire periph_out_s periph_in,
   output periph_in_s periph_out,
   output logic edge_irq_out
);

   ////////////////////////////////////////////////////////////////////
   // Registers and synchronised pins

   byte_t first_latch;
   byte_t first_port_direction;
   byte_t second_latch;
   byte_t second_port_direction;
   byte_t third_latch;
   byte_t third_port_direction;
   byte_t third_port_function_select;
   byte_t first_sync;
   byte_t second_sync;
   byte_t third_sync;
   byte_t third_drive_en;
   byte_t third_drive_val;
   byte_t next_rdata;
   logic stop_meta;
   logic stop_active;
   logic edge_prev;

   pin_sync8 first_sync_inst (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .async_in(first_port_pins_in),
      .sync_out(first_sync)
   );

   pin_sync8 second_sync_inst (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .async_in(second_port_pins_in),
      .sync_out(second_sync)
   );

   pin_sync8 third_sync_inst (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .async_in(third_port_pins_in),
      .sync_out(third_sync)
   );

   // Read value: pin level for inputs, latch for outputs
   function automatic byte_t port_read(input byte_t dir, input byte_t pins,
                                       input byte_t latch);
      port_read = (dir & pins) | (~dir & latch);
   endfunction

   // Pin enables, active low, all released during stop
   function automatic byte_t oe_n(input byte_t drive, input logic stop);
      oe_n = stop ? 8'hff : ~drive;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Hardware stop synchroniser

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stop_meta <= 1'b0;
         stop_active <= 1'b0;
      end else begin
         stop_meta <= ~hw_stop_n_in;
         stop_active <= stop_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register writes

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         first_latch <= `LATCH_RESET;
         second_latch <= `LATCH_RESET;
         third_latch <= `LATCH_RESET;
      end else if (reg_req_in.wr) begin
         case (reg_req_in.addr)
            `ADDR_FIRST_LATCH: first_latch <= reg_req_in.wdata;
            `ADDR_SECOND_LATCH: second_latch <= reg_req_in.wdata;
            `ADDR_THIRD_LATCH: third_latch <= reg_req_in.wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         first_port_direction <= `DIR_RESET;
         second_port_direction <= `DIR_RESET;
         third_port_direction <= `DIR_RESET;
         third_port_function_select <= `FSEL_RESET;
      end else if (reg_req_in.wr) begin
         case (reg_req_in.addr)
            `ADDR_FIRST_DIR: first_port_direction <= reg_req_in.wdata;
            `ADDR_SECOND_DIR: second_port_direction <= reg_req_in.wdata;
            `ADDR_THIRD_DIR: third_port_direction <= reg_req_in.wdata;
            `ADDR_THIRD_FSEL:
               third_port_function_select <= reg_req_in.wdata;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register reads

   always_comb begin
      next_rdata = `UNMAPPED_READ;
      case (reg_req_in.addr)
         `ADDR_FIRST_LATCH:
            next_rdata = port_read(first_port_direction, first_sync,
                                   first_latch);
         `ADDR_FIRST_DIR: next_rdata = first_port_direction;
         `ADDR_SECOND_LATCH:
            next_rdata = port_read(second_port_direction, second_sync,
                                   second_latch);
         `ADDR_SECOND_DIR: next_rdata = second_port_direction;
         `ADDR_THIRD_LATCH:
            next_rdata = port_read(~third_drive_en, third_sync,
                                   third_drive_val);
         `ADDR_THIRD_DIR: next_rdata = third_port_direction;
         `ADDR_THIRD_FSEL: next_rdata = third_port_function_select;
         `ADDR_STATUS: next_rdata = {7'h00, stop_active};
         default: next_rdata = `UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_req_in.rd) begin
         reg_rdata_out <= next_rdata;
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Third port role mux

   always_comb begin
      third_drive_en = ~third_port_direction;
      third_drive_val = third_latch;
      // select bit gives pin to peripheral
      if (third_port_function_select[`PIN_TXD]) begin
         third_drive_en[`PIN_TXD] = 1'b1;
         third_drive_val[`PIN_TXD] = periph_in.txd;
      end
      if (third_port_function_select[`PIN_RXD]) begin
         third_drive_en[`PIN_RXD] = 1'b0;
         third_drive_val[`PIN_RXD] = 1'b0;
      end
      // clock driven only with internal source
      if (third_port_function_select[`PIN_SCK]) begin
         third_drive_en[`PIN_SCK] = periph_in.sck_internal;
         third_drive_val[`PIN_SCK] = periph_in.sck_out;
      end
      if (third_port_function_select[`PIN_EDGE]) begin
         third_drive_en[`PIN_EDGE] = 1'b0;
         third_drive_val[`PIN_EDGE] = 1'b0;
      end
      if (third_port_function_select[`PIN_TIMER]) begin
         third_drive_en[`PIN_TIMER] = 1'b1;
         third_drive_val[`PIN_TIMER] = periph_in.timer_wave;
      end
      if (third_port_function_select[`PIN_COUNT]) begin
         third_drive_en[`PIN_COUNT] = 1'b0;
         third_drive_val[`PIN_COUNT] = 1'b0;
      end
      if (third_port_function_select[`PIN_CO0]) begin
         third_drive_en[`PIN_CO0] = 1'b1;
         third_drive_val[`PIN_CO0] = periph_in.count_wave_0;
      end
      if (third_port_function_select[`PIN_CO1]) begin
         third_drive_en[`PIN_CO1] = 1'b1;
         third_drive_val[`PIN_CO1] = periph_in.count_wave_1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin drivers

   assign first_port_pins_oe_n_out =
      oe_n(~first_port_direction, stop_active);
   assign second_port_pins_oe_n_out =
      oe_n(~second_port_direction, stop_active);
   assign third_port_pins_oe_n_out = oe_n(third_drive_en, stop_active);

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         first_port_pins_out <= `LATCH_RESET;
         second_port_pins_out <= `LATCH_RESET;
         third_port_pins_out <= `LATCH_RESET;
      end else begin
         first_port_pins_out <= first_latch;
         second_port_pins_out <= second_latch;
         third_port_pins_out <= third_drive_val;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Inputs to peripherals

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         periph_out <= '0;
      end else begin
         periph_out.rxd <= third_port_function_select[`PIN_RXD] ?
                           third_sync[`PIN_RXD] : 1'b1;
         periph_out.sck_in <= third_sync[`PIN_SCK];
         periph_out.edge_pin <= third_port_function_select[`PIN_EDGE] ?
                                third_sync[`PIN_EDGE] : 1'b1;
         periph_out.counter_pulse <=
            third_port_function_select[`PIN_COUNT] &
            third_sync[`PIN_COUNT];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         edge_prev <= 1'b1;
         edge_irq_out <= 1'b0;
      end else begin
         edge_prev <= third_sync[`PIN_EDGE];
         edge_irq_out <= third_port_function_select[`PIN_EDGE] &
                         edge_prev & ~third_sync[`PIN_EDGE];
      end
   end

endmodule

// *** hw/port_pins_cfg.svh ***
// Register offsets, reset values and pin positions for the pin-control block
`ifndef PORT_PINS_CFG_SVH
`define PORT_PINS_CFG_SVH

`define ADDR_FIRST_LATCH 4'h0
`define ADDR_FIRST_DIR 4'h1
`define ADDR_SECOND_LATCH 4'h2
`define ADDR_SECOND_DIR 4'h3
`define ADDR_THIRD_LATCH 4'h4
`define ADDR_THIRD_DIR 4'h5
`define ADDR_THIRD_FSEL 4'h6
`define ADDR_STATUS 4'h7

// Direction bit 1 = input, as after reset
`define DIR_RESET 8'hff
`define LATCH_RESET 8'h00
`define FSEL_RESET 8'h00
`define UNMAPPED_READ 8'h00

`define PIN_TXD 0
`define PIN_RXD 1
`define PIN_SCK 2
`define PIN_EDGE 3
`define PIN_TIMER 4
`define PIN_COUNT 5
`define PIN_CO0 6
`define PIN_CO1 7

`endif

// *** hw/port_pins_pkg.sv ***
// Types shared by the pin-control block
package port_pins_pkg;

   typedef logic [7:0] byte_t;

   // Peripheral signals that drive third-port pins in control mode
   typedef struct packed {
      logic txd;
      logic sck_out;
      logic sck_internal;
      logic timer_wave;
      logic count_wave_0;
      logic count_wave_1;
   } periph_out_s;

   // Pin levels handed back to the peripherals
   typedef struct packed {
      logic rxd;
      logic sck_in;
      logic edge_pin;
      logic counter_pulse;
   } periph_in_s;

   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      byte_t wdata;
      logic wr;
      logic rd;
   } reg_req_s;

endpackage

// *** testbench/pin_board.sv ***
// Board-side model of one group of eight pins
`timescale 1ns/1ps
module pin_board
   import port_pins_pkg::*;
(
   // Device side
   input wire byte_t drv_in,
   input wire byte_t oe_n_in,
   // Board side
   input wire byte_t ext_in,
   output byte_t level_out
);
   // board drives released lines, no pull-up
   assign level_out = (drv_in & ~oe_n_in) | (ext_in & oe_n_in);
endmodule

// *** testbench/port_abc_properties.sv ***
// Assertions on the pin-control block ports
`timescale 1ns/1ps
`include "port_pins_cfg.svh"
module port_abc_checker
   import port_pins_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Inputs
   input wire logic hw_stop_n_in,
   input wire reg_req_s reg_req_in,
   input wire periph_out_s periph_in,
   // Outputs
   input wire byte_t first_port_pins_out,
   input wire byte_t first_port_pins_oe_n_out,
   input wire byte_t second_port_pins_oe_n_out,
   input wire byte_t third_port_pins_oe_n_out,
   input wire logic edge_irq_out
);
   byte_t dir_a, dir_b, dir_c, fsel;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Mirror of the mode registers
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dir_a <= `DIR_RESET;
         dir_b <= `DIR_RESET;
         dir_c <= `DIR_RESET;
         fsel <= `FSEL_RESET;
      end else if (reg_req_in.wr) begin
         case (reg_req_in.addr)
            `ADDR_FIRST_DIR: dir_a <= reg_req_in.wdata;
            `ADDR_SECOND_DIR: dir_b <= reg_req_in.wdata;
            `ADDR_THIRD_DIR: dir_c <= reg_req_in.wdata;
            `ADDR_THIRD_FSEL: fsel <= reg_req_in.wdata;
            default: ;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////
   sequence s_run;
      hw_stop_n_in [*3];
   endsequence
   sequence s_latch_wr;
      reg_req_in.wr && reg_req_in.addr == `ADDR_FIRST_LATCH ##1
         !reg_req_in.wr;
   endsequence
   chk_reset_float: assert property (
      $rose(rst_n_in) |-> {first_port_pins_oe_n_out,
      second_port_pins_oe_n_out, third_port_pins_oe_n_out} == 24'hffffff)
      else $error("pins driven after reset");
   chk_stop_float: assert property (
      !hw_stop_n_in [*3] |-> {first_port_pins_oe_n_out,
      second_port_pins_oe_n_out, third_port_pins_oe_n_out} == 24'hffffff)
      else $error("pins driven in stop");
   chk_dir_ab: assert property (s_run |->
      first_port_pins_oe_n_out == dir_a && second_port_pins_oe_n_out == dir_b)
      else $error("first or second port direction wrong");
   chk_dir_port_c: assert property (s_run |->
      (third_port_pins_oe_n_out | fsel) == (dir_c | fsel))
      else $error("third port direction wrong");
   chk_ctl_drive: assert property (s_run |->
      (third_port_pins_oe_n_out & fsel & 8'hd1) == 8'h00)
      else $error("control output pin not driven");
   chk_ctl_input: assert property (s_run |->
      (third_port_pins_oe_n_out & fsel & 8'h2a) == (fsel & 8'h2a))
      else $error("control input pin driven");
   chk_sck_dir: assert property (
      s_run ##0 fsel[2] && $stable(periph_in.sck_internal) |->
      third_port_pins_oe_n_out[2] == !periph_in.sck_internal)
      else $error("serial clock direction wrong");
   chk_latch_out: assert property (s_latch_wr |=>
      first_port_pins_out == $past(reg_req_in.wdata, 2))
      else $error("latch value not on pins");
   chk_irq_pulse: assert property (edge_irq_out |=> !edge_irq_out)
      else $error("interrupt pulse too long");
   chk_irq_gated: assert property (!fsel[3] [*4] |-> !edge_irq_out)
      else $error("interrupt in port mode");
endmodule

bind port_abc_pin_control port_abc_checker i_checker (.ref_clk_in,
   .rst_n_in, .hw_stop_n_in, .reg_req_in, .periph_in, .first_port_pins_out,
   .first_port_pins_oe_n_out, .second_port_pins_oe_n_out,
   .third_port_pins_oe_n_out, .edge_irq_out);

// *** testbench/testbench.sv ***
// Self-checking bench for the pin-control block
`timescale 1ns/1ps
`include "port_pins_cfg.svh"
module testbench;
   import port_pins_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic stop_n = 1'b1;
   logic irq;
   reg_req_s req = '0;
   periph_out_s per = '0;
   periph_in_s pout;
   byte_t ext_a = 8'h3c, ext_b = 8'hc3, ext_c = 8'hff;
   byte_t lvl_a, lvl_b, lvl_c, out_a, out_b, out_c, oe_a, oe_b, oe_c, rdata;
   int error_cnt = 0, checked = 0, cycles = 0, n;

   always #12.5 clk = ~clk;
   pin_board i_pa (.drv_in(out_a), .oe_n_in(oe_a), .ext_in(ext_a),
      .level_out(lvl_a));
   pin_board i_pb (.drv_in(out_b), .oe_n_in(oe_b), .ext_in(ext_b),
      .level_out(lvl_b));
   pin_board i_pc (.drv_in(out_c), .oe_n_in(oe_c), .ext_in(ext_c),
      .level_out(lvl_c));
   port_abc_pin_control i_dut (.ref_clk_in(clk), .rst_n_in(rst_n),
      .hw_stop_n_in(stop_n), .reg_req_in(req), .reg_rdata_out(rdata),
      .first_port_pins_in(lvl_a), .first_port_pins_out(out_a),
      .first_port_pins_oe_n_out(oe_a), .second_port_pins_in(lvl_b),
      .second_port_pins_out(out_b), .second_port_pins_oe_n_out(oe_b),
      .third_port_pins_in(lvl_c), .third_port_pins_out(out_c),
      .third_port_pins_oe_n_out(oe_c), .periph_in(per),
      .periph_out(pout), .edge_irq_out(irq));
   ////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("Checks %0d, errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input byte_t d);
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [3:0] a, input byte_t e);
      @(posedge clk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      req <= '0;
      #1;
      chk(rdata, e);
   endtask
   function automatic byte_t ctl(input periph_out_s p);
      return {p.count_wave_1, p.count_wave_0, 1'b0, p.timer_wave, 1'b0,
         p.sck_out, 1'b0, p.txd};
   endfunction
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         error_cnt++;
         stop_test;
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      tick(1);
      chk({oe_a, oe_b, oe_c}, 24'hffffff);
      rd(`ADDR_THIRD_FSEL, `FSEL_RESET);
      rd(`ADDR_FIRST_DIR, `DIR_RESET);
      for (n = 0; n < 2; n++) begin
         wr(n ? `ADDR_SECOND_LATCH : `ADDR_FIRST_LATCH, 8'ha5);
         wr(n ? `ADDR_SECOND_DIR : `ADDR_FIRST_DIR, 8'h0f);
         tick(2);
         chk(n ? {out_b, oe_b} : {out_a, oe_a}, 24'ha50f);
         rd(n ? `ADDR_SECOND_LATCH : `ADDR_FIRST_LATCH,
            n ? 8'ha3 : 8'hac);
      end
      @(posedge clk);
      stop_n <= 1'b0;
      tick(4);
      chk({oe_a, oe_b, oe_c}, 24'hffffff);
      rd(`ADDR_STATUS, 8'h01);
      @(posedge clk);
      stop_n <= 1'b1;
      tick(4);
      chk({oe_a, oe_b}, 24'h0f0f);
      wr(`ADDR_THIRD_DIR, 8'h00);
      wr(`ADDR_THIRD_FSEL, 8'hff);
      for (n = 0; n < 2; n++) begin
         @(posedge clk);
         per <= n ? 6'h1a : 6'h2d;
         tick(3);
         chk(oe_c, 24'h2a);
         chk(out_c & 8'hd5, ctl(per));
      end
      @(posedge clk);
      per <= '0;
      ext_c <= 8'h2c;
      tick(5);
      chk(oe_c, 24'h2e);
      chk(pout, 24'h7);
      @(posedge clk);
      ext_c <= 8'h24;
      n = 0;
      repeat (8) begin
         tick(1);
         if (irq === 1'b1)
            n++;
      end
      chk(24'(n), 24'h1);
      wr(`ADDR_THIRD_FSEL, 8'h0f);
      tick(2);
      chk(oe_c, 24'h0e);
      wr(`ADDR_THIRD_LATCH, 8'h5a);
      tick(2);
      chk(out_c & 8'hf0, 24'h50);
      rd(`ADDR_THIRD_LATCH, 8'h54);
      chk(pout, 24'h4);
      wr(4'h8, 8'hff);
      rd(4'h8, `UNMAPPED_READ);
      wr(`ADDR_STATUS, 8'hff);
      rd(`ADDR_STATUS, 8'h00);
      stop_test;
   end
endmodule
